// ### flash_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(parameter int PROG_CYC = 30) (
  // Clock and pins
  input  wire logic        clk,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        wr_en_n,
  input  wire logic        pwr_down_n,
  input  wire logic [17:0] flash_addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [15:0] dq_in,
  // Fault injection
  input  wire logic        fail_next
);
  logic [15:0] mem [16];
  logic [7:0]  operation_status_reg, stat_lat_reg;
  logic        stat_mode_reg, setup_reg;
  logic        rd_prev_reg = 1'h0;
  logic [15:0] last_q_reg  = 16'h0;
  int          busy_reg;
  wire logic   rd_now = !chip_sel_n && !out_en_n;
  wire logic   wr_now = !chip_sel_n && !wr_en_n && dq_oe;
  wire logic [7:0]  stat_out = (rd_now && !rd_prev_reg) ? operation_status_reg : stat_lat_reg;
  wire logic [15:0] rd_val = stat_mode_reg ? {8'h00, stat_out} : mem[flash_addr[3:0]];
  // Released bus never repeats the last value
  assign dq_in = rd_now ? rd_val : ~last_q_reg;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
  always @(posedge clk) begin
    rd_prev_reg <= rd_now;
    if (rd_now) last_q_reg <= rd_val;
    if (rd_now && !rd_prev_reg) stat_lat_reg <= operation_status_reg;
    if (!pwr_down_n) begin
      operation_status_reg <= 8'h80;
      stat_mode_reg <= 1'h0;
      setup_reg <= 1'h0;
      busy_reg <= 0;
    end else if (busy_reg > 0) begin
      busy_reg <= busy_reg - 1;
      if (busy_reg == 1) operation_status_reg[7] <= 1'h1;
      if (wr_now && dq_out[7:0] == 8'h70) stat_mode_reg <= 1'h1;
    end else if (wr_now && setup_reg) begin
      setup_reg <= 1'h0;
      mem[flash_addr[3:0]] <= mem[flash_addr[3:0]] & dq_out;
      operation_status_reg[7] <= 1'h0;
      busy_reg <= PROG_CYC;
      if (fail_next) operation_status_reg[4] <= 1'h1;
    end else if (wr_now) begin
      case (dq_out[7:0])
        8'h50: operation_status_reg[5:3] <= 3'h0;
        8'h40, 8'h10: begin
          setup_reg <= 1'h1;
          stat_mode_reg <= 1'h1;
        end
        8'h70: stat_mode_reg <= 1'h1;
        8'hFF: stat_mode_reg <= 1'h0;
        default: ;
      endcase
    end
  end
endmodule // flash_device_model
`default_nettype wire

// ### flash_host_pkg.sv
package flash_host_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] ADDR_OFF   = 8'h04;
  localparam logic [7:0] WDATA_OFF  = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] RDATA_OFF  = 8'h10;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int CTRL_START    = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int ST_BUSY       = 0;
  localparam int ST_DONE       = 1;
  localparam int ST_PROG_ERR   = 2;
  localparam int ST_STAT_LSB   = 8;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  // ----------------------------------------
  // Operations requested by software
  // ----------------------------------------
  localparam logic [1:0] OP_PROGRAM  = 2'h0;
  localparam logic [1:0] OP_CLEAR    = 2'h1;
  localparam logic [1:0] OP_RDSTATUS = 2'h2;
  localparam logic [1:0] OP_RDARRAY  = 2'h3;
  // ----------------------------------------
  // Device command codes and status bits
  // ----------------------------------------
  localparam logic [7:0] CMD_CLEAR    = 8'h50;
  localparam logic [7:0] CMD_PROG     = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_RDSTATUS = 8'h70;
  localparam logic [7:0] CMD_RDARRAY  = 8'hFF;
  localparam int STAT_READY     = 7;
  localparam int STAT_PROG_FAIL = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS     = 100;
  localparam int PULSE_NS   = 200;
  localparam int GAP_NS     = 100;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC    = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC   = 2;
  localparam int READ_CYC   = PULSE_CYC + SYNC_CYC + 1;
  localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYC - 1);
  localparam logic [3:0] GAP_LAST   = 4'(GAP_CYC - 1);
  localparam logic [3:0] READ_LAST  = 4'(READ_CYC - 1);
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_WCMD  = 6'h02,
    S_WDATA = 6'h04,
    S_READ  = 6'h08,
    S_GAP   = 6'h10,
    S_FIN   = 6'h20
  } seq_state_t;
endpackage

// ### flash_program_status_control.sv
// How it works
// RULE1 - Device engine sets status bits 3-7, clears only 6 and 7.
// RULE2 - Bits 3-5 clear only by the clear-status command.
// RULE3 - Error bits accumulate across operations; one read reveals any failure.
// RULE4 - After clear-status, any other valid command may follow.
// RULE5 - Host writes a read-source command before every read cycle; while polling, the code repeats status reads after a single 70H.
// RULE6 - Program is setup command then a write of address and data.
// RULE7 - Device programs then verifies the addressed word internally.
// RULE8 - Programming only turns ones into zeros.
// RULE9 - Writing a one leaves the cell alone and raises no error.
// RULE10 - Status bit 7 is zero while busy, one when ready.
// RULE11 - Host polls by toggling a strobe low for each status read.
// RULE12 - While programming, only read-status is accepted.
// RULE13 - Host checks ready bit before trusting fail bits.
// RULE14 - Clear-status is data 50H at any address.
// RULE15 - Program setup is 40H or 10H, both equal.
// RULE16 - Read-status is 70H; reads then return status at any address.
// RULE17 - Status is latched on the later falling strobe edge of a read.
`timescale 1ns/1ps
`default_nettype none
module flash_program_status_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Flash device pins
  output logic             chip_sel_n,
  output logic             out_en_n,
  output logic             wr_en_n,
  output logic             pwr_down_n,
  output logic      [17:0] flash_addr,
  output logic      [15:0] dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  flash_host_pkg::seq_state_t state_reg;
  flash_host_pkg::seq_state_t prev_reg;
  logic [3:0]  cnt_reg;
  logic [1:0]  op_reg;
  logic [17:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0]  status_byte_reg;
  logic        poll_cmd_reg;
  logic        done_reg;
  logic        err_reg;
  logic [15:0] dq_meta_reg;
  logic [15:0] dq_sync_reg;
  logic        wb_req;
  logic        start_req;
  logic        busy;
  logic        read_end;

  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busy      = (state_reg != flash_host_pkg::S_IDLE);
  assign read_end  = (state_reg == flash_host_pkg::S_READ) && (cnt_reg == flash_host_pkg::READ_LAST);
  assign start_req = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == flash_host_pkg::CTRL_OFF)
                     & wb_dat_i[flash_host_pkg::CTRL_START] & ~busy;

  function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] off);
    byte_hit = (a == off);
  endfunction

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  function automatic logic [31:0] status_word(input logic busy_i, input logic done_i, input logic err_i,
                                              input logic [7:0] stat_i);
    status_word                                   = 32'h00000000;
    status_word[flash_host_pkg::ST_BUSY]          = busy_i;
    status_word[flash_host_pkg::ST_DONE]          = done_i;
    status_word[flash_host_pkg::ST_PROG_ERR]      = err_i;
    status_word[flash_host_pkg::ST_STAT_LSB +: 8] = stat_i;
  endfunction

  // ----------------------------------------
  // Input synchroniser for the data pins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    dq_meta_reg <= dq_in;
    dq_sync_reg <= dq_meta_reg;
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        if (byte_hit(wb_adr_i, flash_host_pkg::ADDR_OFF)) begin
          wb_dat_o <= {14'h0000, addr_reg};
        end else if (byte_hit(wb_adr_i, flash_host_pkg::WDATA_OFF)) begin
          wb_dat_o <= {16'h0000, wdata_reg};
        end else if (byte_hit(wb_adr_i, flash_host_pkg::STATUS_OFF)) begin
          wb_dat_o <= status_word(busy, done_reg, err_reg, status_byte_reg);
        end else if (byte_hit(wb_adr_i, flash_host_pkg::RDATA_OFF)) begin
          wb_dat_o <= {16'h0000, rdata_reg};
        end
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg  <= 18'h00000;
      wdata_reg <= 16'h0000;
    end else if (wb_req && wb_we_i && !busy) begin
      if (byte_hit(wb_adr_i, flash_host_pkg::ADDR_OFF)) begin
        if (wb_sel_i[0]) addr_reg[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) addr_reg[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) addr_reg[17:16] <= wb_dat_i[17:16];
      end else if (byte_hit(wb_adr_i, flash_host_pkg::WDATA_OFF)) begin
        if (wb_sel_i[0]) wdata_reg[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) wdata_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= flash_host_pkg::S_IDLE;
      prev_reg  <= flash_host_pkg::S_IDLE;
      cnt_reg   <= 4'h0;
      op_reg    <= flash_host_pkg::OP_PROGRAM;
      poll_cmd_reg <= 1'b0;
    end else begin
      case (state_reg)
        flash_host_pkg::S_IDLE: begin
          cnt_reg <= 4'h0;
          if (start_req) begin
            op_reg    <= wb_dat_i[flash_host_pkg::CTRL_OP_LSB +: 2];
            poll_cmd_reg <= 1'b0;
            state_reg <= flash_host_pkg::S_WCMD;
          end
        end
        flash_host_pkg::S_WCMD, flash_host_pkg::S_WDATA: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == flash_host_pkg::PULSE_LAST) begin
            cnt_reg   <= 4'h0;
            prev_reg  <= state_reg;
            state_reg <= flash_host_pkg::S_GAP;
          end
        end
        flash_host_pkg::S_READ: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == flash_host_pkg::READ_LAST) begin
            cnt_reg  <= 4'h0;
            prev_reg <= state_reg;
            // Keep polling until the device reports ready
            if (op_reg == flash_host_pkg::OP_PROGRAM && !dq_sync_reg[flash_host_pkg::STAT_READY]) begin // RULE10
              state_reg <= flash_host_pkg::S_GAP;
            end else begin
              state_reg <= flash_host_pkg::S_FIN;
            end
          end
        end
        flash_host_pkg::S_GAP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == flash_host_pkg::GAP_LAST) begin
            cnt_reg <= 4'h0;
            if (prev_reg == flash_host_pkg::S_WCMD && poll_cmd_reg) begin
              state_reg <= flash_host_pkg::S_READ; // RULE5
            end else if (prev_reg == flash_host_pkg::S_WCMD) begin
              if (op_reg == flash_host_pkg::OP_PROGRAM) begin
                state_reg <= flash_host_pkg::S_WDATA; // RULE6
              end else if (op_reg == flash_host_pkg::OP_CLEAR) begin
                state_reg <= flash_host_pkg::S_FIN; // RULE4
              end else begin
                state_reg <= flash_host_pkg::S_READ; // RULE5
              end
            end else if (prev_reg == flash_host_pkg::S_WDATA) begin
              // Point the read path at status before polling
              poll_cmd_reg <= 1'b1;
              state_reg    <= flash_host_pkg::S_WCMD; // RULE5 RULE16
            end else begin
              // Only status reads follow while programming runs
              state_reg <= flash_host_pkg::S_READ; // RULE12 RULE11
            end
          end
        end
        flash_host_pkg::S_FIN: begin
          state_reg <= flash_host_pkg::S_IDLE;
        end
        default: begin
          state_reg <= flash_host_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Flash pin drive
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      chip_sel_n <= 1'b1;
      out_en_n   <= 1'b1;
      wr_en_n    <= 1'b1;
      pwr_down_n <= 1'b0;
      flash_addr <= 18'h00000;
      dq_out     <= 16'h0000;
      dq_oe      <= 1'b0;
    end else begin
      pwr_down_n <= 1'b1;
      chip_sel_n <= 1'b1;
      out_en_n   <= 1'b1;
      wr_en_n    <= 1'b1;
      dq_oe      <= 1'b0;
      flash_addr <= addr_reg;
      case (state_reg)
        flash_host_pkg::S_WCMD: begin
          chip_sel_n <= (cnt_reg == flash_host_pkg::PULSE_LAST);
          wr_en_n    <= (cnt_reg == flash_host_pkg::PULSE_LAST);
          dq_oe      <= 1'b1;
          if (poll_cmd_reg) begin
            dq_out <= {8'h00, flash_host_pkg::CMD_RDSTATUS}; // RULE16
          end else begin
            case (op_reg)
              flash_host_pkg::OP_PROGRAM:  dq_out <= {8'h00, flash_host_pkg::CMD_PROG};     // RULE15
              flash_host_pkg::OP_CLEAR:    dq_out <= {8'h00, flash_host_pkg::CMD_CLEAR};    // RULE14 RULE2
              flash_host_pkg::OP_RDSTATUS: dq_out <= {8'h00, flash_host_pkg::CMD_RDSTATUS}; // RULE16
              default:                     dq_out <= {8'h00, flash_host_pkg::CMD_RDARRAY};
            endcase
          end
        end
        flash_host_pkg::S_WDATA: begin
          chip_sel_n <= (cnt_reg == flash_host_pkg::PULSE_LAST);
          wr_en_n    <= (cnt_reg == flash_host_pkg::PULSE_LAST);
          dq_oe      <= 1'b1;
          dq_out     <= wdata_reg; // RULE6
        end
        flash_host_pkg::S_READ: begin
          // Strobes fall together and rise after each sample
          chip_sel_n <= (cnt_reg == flash_host_pkg::READ_LAST); // RULE11 RULE17
          out_en_n   <= (cnt_reg == flash_host_pkg::READ_LAST);
        end
        default: begin
          dq_out <= dq_out;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Results
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      done_reg <= 1'b0;
    end else if (start_req) begin
      done_reg <= 1'b0;
    end else if (state_reg == flash_host_pkg::S_FIN) begin
      done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg       <= 16'h0000;
      status_byte_reg <= 8'h00;
    end else if (read_end) begin
      rdata_reg <= dq_sync_reg;
      if (op_reg != flash_host_pkg::OP_RDARRAY) begin
        status_byte_reg <= dq_sync_reg[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      err_reg <= 1'b0;
    end else if (state_reg == flash_host_pkg::S_FIN && op_reg == flash_host_pkg::OP_CLEAR) begin
      // Clear op drops the sticky fail flag
      err_reg <= 1'b0;
    end else if (read_end && op_reg == flash_host_pkg::OP_PROGRAM
                 && dq_sync_reg[flash_host_pkg::STAT_READY]) begin // RULE13
      // Fail bit is trusted only once ready is seen
      err_reg <= dq_sync_reg[flash_host_pkg::STAT_PROG_FAIL]; // RULE3
    end
  end
endmodule // flash_program_status_control
`default_nettype wire

// ### flash_program_status_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flash_program_status_control_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Flash pins
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        wr_en_n,
  input wire logic        pwr_down_n,
  input wire logic [17:0] flash_addr,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe,
  input wire logic [15:0] dq_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  sequence cmd_pulse(logic [15:0] code);
    !chip_sel_n && !wr_en_n && dq_oe && dq_out == code;
  endsequence
  property start_sends(logic [1:0] op, logic [15:0] code);
    take && wb_we_i && wb_adr_i == flash_host_pkg::CTRL_OFF && wb_sel_i[0] && wb_dat_i[2:0] == {op, 1'h1}
      |-> ##[1:6] cmd_pulse(code);
  endproperty
  a_ack_answer: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_pd_release: assert property (!$past(srst) |-> pwr_down_n)
    else $error("power-down pin low after reset release");
  a_write_strobe: assert property (!wr_en_n |-> !chip_sel_n && dq_oe && out_en_n)
    else $error("write pulse without select and driven data");
  a_read_shape: assert property ($fell(out_en_n) |-> (!chip_sel_n && !out_en_n)[*4] ##1 out_en_n)
    else $error("status read strobe of wrong length");
  a_setup_data: assert property (cmd_pulse(16'h0040) |=> out_en_n throughout (##[1:8] !wr_en_n))
    else $error("program setup not followed by data write");
  a_setup_cmd: assert property (start_sends(2'h0, 16'h0040))
    else $error("program op did not send setup command");
  a_clear_cmd: assert property (start_sends(2'h1, 16'h0050))
    else $error("clear op did not send clear command");
  a_status_cmd: assert property (start_sends(2'h2, 16'h0070))
    else $error("status op did not send read-status command");
  a_array_cmd: assert property (start_sends(2'h3, 16'h00FF))
    else $error("array op did not send read-array command");
endmodule // flash_program_status_control_monitor
`default_nettype wire

// ### test_flash_program_status_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_status_control;
  logic        clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fail_next;
  logic        chip_sel_n, out_en_n, wr_en_n, pwr_down_n, dq_oe;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i;
  logic [15:0] dq_out, dq_in;
  logic [17:0] flash_addr;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          bad_count = 0;
  int          tests_run = 0;
  flash_program_status_control flash_program_status_control_inst (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .chip_sel_n, .out_en_n, .wr_en_n, .pwr_down_n,
    .flash_addr, .dq_out, .dq_oe, .dq_in);
  flash_device_model #(.PROG_CYC(30)) flash_device_model_inst (.clk, .chip_sel_n, .out_en_n, .wr_en_n,
    .pwr_down_n, .flash_addr, .dq_out, .dq_oe, .dq_in, .fail_next);
  task automatic close_out;
    $display("Checks %0d, errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    close_out();
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 20) hang();
    @(posedge clk);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      wb(1'h0, flash_host_pkg::STATUS_OFF, 32'h0);
      n++;
    end while (rd[flash_host_pkg::ST_DONE] !== 1'h1 && n < 100);
    if (n >= 100) hang();
  endtask
  task automatic run_op(input logic [1:0] op);
    wb(1'h1, flash_host_pkg::CTRL_OFF, {29'h0, op, 1'h1});
    wait_done();
  endtask
  task automatic prog(input logic [17:0] a, input logic [15:0] d, input logic f);
    wb(1'h1, flash_host_pkg::ADDR_OFF, {14'h0, a});
    wb(1'h1, flash_host_pkg::WDATA_OFF, {16'h0, d});
    fail_next <= f;
    run_op(flash_host_pkg::OP_PROGRAM);
  endtask
  task automatic rd_array(input logic [17:0] a);
    wb(1'h1, flash_host_pkg::ADDR_OFF, {14'h0, a});
    run_op(flash_host_pkg::OP_RDARRAY);
    wb(1'h0, flash_host_pkg::RDATA_OFF, 32'h0);
  endtask
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    srst = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    fail_next = 1'h0;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    wb(1'h0, flash_host_pkg::STATUS_OFF, 32'h0);
    chk("status_idle", {13'h0, rd[2:0]}, 16'h0000);
    prog(18'h00003, 16'h0FF0, 1'h0);
    chk("status_prog_ok", rd[15:0], 16'h8002);
    prog(18'h00003, 16'hFF0F, 1'h1);
    chk("status_prog_fail", rd[15:0], 16'h9006);
    prog(18'h00005, 16'h1234, 1'h0);
    chk("status_sticky", rd[15:0], 16'h9006);
    run_op(flash_host_pkg::OP_RDSTATUS);
    chk("status_byte", {8'h00, rd[15:8]}, 16'h0090);
    rd_array(18'h00003);
    chk("array_and", rd[15:0], 16'h0F00);
    run_op(flash_host_pkg::OP_CLEAR);
    prog(18'h00005, 16'hFFFF, 1'h0);
    chk("status_cleared", rd[15:0], 16'h8002);
    rd_array(18'h00005);
    chk("array_keep", rd[15:0], 16'h1234);
    wb(1'h1, flash_host_pkg::WDATA_OFF, 32'h000000FF);
    wb(1'h1, flash_host_pkg::CTRL_OFF, {29'h0, flash_host_pkg::OP_PROGRAM, 1'h1});
    wb(1'h1, flash_host_pkg::WDATA_OFF, 32'h0000AAAA);
    wb(1'h0, flash_host_pkg::WDATA_OFF, 32'h0);
    chk("wdata_busy", rd[15:0], 16'h00FF);
    wait_done();
    rd_array(18'h00005);
    chk("array_busy_prog", rd[15:0], 16'h0034);
    wb(1'h0, 8'h20, 32'h0);
    chk("unmapped", rd[15:0], 16'h0000);
    close_out();
  end
endmodule // test_flash_program_status_control
bind flash_program_status_control flash_program_status_control_monitor flash_program_status_control_monitor_inst (
  .clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .chip_sel_n, .out_en_n, .wr_en_n, .pwr_down_n, .flash_addr, .dq_out, .dq_oe, .dq_in);
`default_nettype wire
